// file: rtl/uart_lfms_pkg.sv
package uart_lfms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  OFS_DATA       = 5'h00;
  localparam logic [4:0]  OFS_ENABLE     = 5'h04;
  localparam logic [4:0]  OFS_FIFO       = 5'h08;
  localparam logic [4:0]  OFS_LINE_CTRL  = 5'h0C;
  localparam logic [4:0]  OFS_MODEM_CTRL = 5'h10;
  localparam logic [4:0]  OFS_LINE_STAT  = 5'h14;
  localparam logic [4:0]  OFS_CONFIG     = 5'h18;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  RST_LINE_CTRL  = 8'h00;
  localparam logic [7:0]  RST_MODEM_CTRL = 8'h00;
  localparam logic [7:0]  RST_ENABLE     = 8'h00;
  localparam logic [7:0]  RST_DIV_LOW    = 8'h01;
  localparam logic [7:0]  RST_DIV_HIGH   = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          LC_PAR_EN      = 3;
  localparam int          LC_PAR_EVEN    = 4;
  localparam int          LC_PAR_FORCE   = 5;
  localparam int          LC_BREAK       = 6;
  localparam int          LC_DIV_SEL     = 7;
  localparam int          LC_STOP        = 2;
  localparam int          MC_TERM_RDY    = 0;
  localparam int          MC_REQ_SEND    = 1;
  localparam int          MC_RING_LOOP   = 2;
  localparam int          MC_AUX_TWO     = 3;
  localparam int          MC_LOOP        = 4;
  localparam int          MC_XON_ANY     = 5;
  localparam int          MC_INFRARED    = 6;
  localparam int          MC_PRESCALE    = 7;
  localparam int          EN_RX_DATA     = 0;
  localparam int          EN_LINE_STAT   = 2;
  localparam int          CF_ALT_BUS     = 0;
  localparam int          CF_SW_FLOW     = 1;

  ////////////////////////////////////////////////////////////////////////////
  // cycle counts, in 16x baud ticks except PRESCALE_LAST, which counts clocks; then the XON and XOFF characters
  localparam logic [3:0]  TICKS_MID      = 4'h7;
  localparam logic [3:0]  TICKS_LAST     = 4'hF;
  localparam logic [5:0]  STOP_ONE       = 6'h0F;
  localparam logic [5:0]  STOP_ONEHALF   = 6'h17;
  localparam logic [5:0]  STOP_TWO       = 6'h1F;
  localparam logic [3:0]  IR_PULSE       = 4'h3;
  localparam logic [4:0]  IR_STRETCH     = 5'h10;
  localparam logic [1:0]  PRESCALE_LAST  = 2'h3;
  localparam logic [7:0]  CHAR_XON       = 8'h11;
  localparam logic [7:0]  CHAR_XOFF      = 8'h13;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } rx_state_t;

  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic termReadyN;
    logic reqSendN;
    logic auxTwoN;
  } modem_out_t;

endpackage : uart_lfms_pkg

// file: rtl/uart_line_format_modem_status.sv
`timescale 1ns/10ps
module uart_line_format_modem_status
  import uart_lfms_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              ce,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // serial line
  input  wire logic              rxPin,
  output logic                   txPin,
  // modem
  input  wire logic              ringIndicatorInN,
  output modem_out_t             modemOut,
  // interrupts
  output logic                   irqOut,
  output logic                   irqDriveN,
  output logic                   irqSharedOut,
  output logic                   irqSharedDriveN
);

  localparam int         AW        = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW+1)'(FIFO_DEPTH);

  generate
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256 || (1 << AW) != FIFO_DEPTH) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two from 2 to 256");
    end
  endgenerate

  typedef rx_entry_t [FIFO_DEPTH-1:0] fifo_mem_t;

  typedef struct packed {
    logic [7:0]  lineCtrl;
    logic [7:0]  modemCtrl;
    logic [7:0]  alertEn;
    logic [7:0]  divLow;
    logic [7:0]  divHigh;
    logic [7:0]  rdData;
    logic        fifoEn;
    logic [1:0]  cfgBits;
    logic        ack;
    logic [1:0]  pre;
    logic [15:0] brg;
    tx_state_t   txSt;
    logic [7:0]  thr;
    logic [7:0]  txSh;
    logic        thrFull;
    logic        txParBit;
    logic        halted;
    logic [5:0]  txTick;
    logic [2:0]  txBit;
    rx_state_t   rxSt;
    logic [3:0]  rxTick;
    logic [2:0]  rxBit;
    logic [7:0]  rxSh;
    logic        rxPar;
    logic        rxZero;
    logic        brkHold;
    logic [4:0]  irHold;
    fifo_mem_t   mem;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic        overrun;
    logic        lsInt;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic parityBit(input logic [7:0] d, input logic [7:0] lc);
    parityBit = lc[LC_PAR_FORCE] ? ~lc[LC_PAR_EVEN]
                                 : ((^d) ^ ~lc[LC_PAR_EVEN]);
  endfunction : parityBit

  function automatic logic anyErr(input fifo_mem_t m, input logic [AW-1:0] rp,
                                  input logic [AW:0] cnt);
    logic          e;
    logic [AW-1:0] idx;
    e = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      idx = rp + AW'(i);
      if ((AW+1)'(i) < cnt) begin
        e = e | m[idx].brk | m[idx].frm | m[idx].par;
      end
    end
    anyErr = e;
  endfunction : anyErr

  logic        preTick;
  logic        tick;
  logic [2:0]  lastBit;
  logic [7:0]  dataMask;
  logic [5:0]  stopLast;
  logic        txLine;
  logic        rxLine;
  logic        loopOn;
  logic        irOn;
  logic        divSel;
  logic        dataReady;
  logic        fifoFull;
  logic [AW:0] fifoLimit;
  rx_entry_t   head;
  logic [7:0]  lineStat;
  logic [7:0]  rdMux;
  logic        ringLevel;
  logic        intActive;
  logic        req;
  logic        done;
  logic        aligned;

  assign loopOn    = s_r.modemCtrl[MC_LOOP];
  assign irOn      = s_r.modemCtrl[MC_INFRARED];
  assign divSel    = s_r.lineCtrl[LC_DIV_SEL];
  // prescaler ticks every fourth clock when enabled
  assign preTick   = ~s_r.modemCtrl[MC_PRESCALE] | (s_r.pre == PRESCALE_LAST);
  assign tick      = preTick & (s_r.brg <= 16'h0001);
  assign lastBit   = 3'h4 + 3'(s_r.lineCtrl[1:0]);
  assign dataMask  = 8'hFF >> (2'h3 - s_r.lineCtrl[1:0]);
  assign stopLast  = ~s_r.lineCtrl[LC_STOP] ? STOP_ONE :
                     (s_r.lineCtrl[1:0] == 2'h0) ? STOP_ONEHALF : STOP_TWO;

  always_comb begin
    case (s_r.txSt)
      TX_START: txLine = 1'b0;
      TX_DATA:  txLine = s_r.txSh[0];
      TX_PAR:   txLine = s_r.txParBit;
      default:  txLine = 1'b1;
    endcase
    txLine = txLine & ~s_r.lineCtrl[LC_BREAK];
  end

  // infrared decode stretches a short high pulse into a low bit
  assign rxLine = loopOn ? txLine :
                  irOn   ? (s_r.irHold == 5'h00) : rxPin;
  // loopback parks the pin at its idle level for the chosen coding
  assign txPin  = loopOn ? ~irOn :
                  irOn   ? (~txLine & (s_r.txTick[3:0] < IR_PULSE)) : txLine;

  assign fifoLimit = s_r.fifoEn ? DEPTH_CNT : (AW+1)'(1);
  assign fifoFull  = s_r.count >= fifoLimit;
  assign dataReady = s_r.count != '0;
  assign head      = s_r.mem[s_r.rdPtr];
  assign lineStat  = {anyErr(s_r.mem, s_r.rdPtr, s_r.count),
                      ~s_r.thrFull & (s_r.txSt == TX_IDLE),
                      ~s_r.thrFull,
                      dataReady & head.brk,
                      dataReady & head.frm,
                      dataReady & head.par,
                      s_r.overrun,
                      dataReady};

  assign ringLevel = loopOn ? s_r.modemCtrl[MC_RING_LOOP] : ~ringIndicatorInN;
  assign intActive = (s_r.alertEn[EN_LINE_STAT] & s_r.lsInt) |
                     (s_r.alertEn[EN_RX_DATA] & dataReady);

  assign req     = read | write;
  assign done    = req & s_r.ack;
  assign aligned = address[1:0] == 2'h0;

  always_comb begin
    rdMux = 8'h00;
    if (aligned) begin
      case (address)
        OFS_DATA:       rdMux = divSel ? s_r.divLow :
                                (dataReady ? head.data : 8'h00);
        OFS_ENABLE:     rdMux = divSel ? s_r.divHigh : s_r.alertEn;
        OFS_FIFO:       rdMux = {7'h00, s_r.fifoEn};
        OFS_LINE_CTRL:  rdMux = s_r.lineCtrl;
        OFS_MODEM_CTRL: rdMux = s_r.modemCtrl;
        OFS_LINE_STAT:  rdMux = lineStat;
        OFS_CONFIG:     rdMux = {3'h0, ringLevel, 2'h0, s_r.cfgBits};
        default:        rdMux = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic          pop;
    logic          pushReq;
    logic          pushOk;
    logic          flush;
    logic          brk;
    logic          isFlow;
    logic          wrLow;
    rx_entry_t     pushVal;
    rx_entry_t     nextHead;
    logic          headEvt;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] nxtPtr;
    pop      = 1'b0;
    pushReq  = 1'b0;
    pushOk   = 1'b0;
    flush    = 1'b0;
    brk      = 1'b0;
    isFlow   = 1'b0;
    wrLow    = write & byteenable[0] & done & aligned;
    pushVal  = '0;
    nextHead = '0;
    headEvt  = 1'b0;
    wrPtr    = s_r.rdPtr + s_r.count[AW-1:0];
    nxtPtr   = s_r.rdPtr + AW'(1);
    s_nxt    = s_r;

    // one wait cycle, then the answer
    s_nxt.ack = req & ~s_r.ack;
    if (read & ~s_r.ack) begin
      s_nxt.rdData = rdMux;
    end

    // baud generator
    s_nxt.pre = s_r.modemCtrl[MC_PRESCALE] ? s_r.pre + 2'h1 : 2'h0;
    if (preTick) begin
      s_nxt.brg = (s_r.brg <= 16'h0001) ? {s_r.divHigh, s_r.divLow}
                                        : s_r.brg - 16'h0001;
    end

    // register writes
    if (wrLow) begin
      case (address)
        OFS_DATA: begin
          if (divSel) begin
            s_nxt.divLow = writedata[7:0];
            // restart the count so a new divisor acts at once, not after the old one drains
            s_nxt.brg    = 16'h0000;
          end else if (~s_r.thrFull) begin
            s_nxt.thr     = writedata[7:0];
            s_nxt.thrFull = 1'b1;
          end
        end
        OFS_ENABLE: begin
          if (divSel) begin
            s_nxt.divHigh = writedata[7:0];
            s_nxt.brg     = 16'h0000;
          end else begin
            s_nxt.alertEn = writedata[7:0];
          end
        end
        OFS_FIFO: begin
          s_nxt.fifoEn = writedata[0];
          flush        = writedata[1] | (writedata[0] != s_r.fifoEn);
        end
        OFS_LINE_CTRL:  s_nxt.lineCtrl  = writedata[7:0];
        OFS_MODEM_CTRL: s_nxt.modemCtrl = writedata[7:0];
        OFS_CONFIG:     s_nxt.cfgBits   = writedata[1:0];
        default: ;
      endcase
    end

    // reads with side effects, at the completing edge
    if (read & done & aligned) begin
      if (address == OFS_DATA && ~divSel && dataReady) begin
        pop = 1'b1;
      end
      if (address == OFS_LINE_STAT) begin
        s_nxt.lsInt = 1'b0;
        // overrun is cleared only if the host actually saw it set; lsInt clears on every such read
        if (s_r.rdData[1]) begin
          s_nxt.overrun = 1'b0;
        end
      end
    end

    // transmitter
    if (s_r.txSt == TX_IDLE) begin
      if (s_r.thrFull & ~s_r.halted) begin
        s_nxt.txSh     = s_r.thr & dataMask;
        s_nxt.txParBit = parityBit(s_r.thr & dataMask, s_r.lineCtrl);
        s_nxt.thrFull  = 1'b0;
        s_nxt.txTick   = 6'h00;
        s_nxt.txSt     = TX_START;
      end
    end else if (tick) begin
      s_nxt.txTick = s_r.txTick + 6'h01;
      case (s_r.txSt)
        TX_START: begin
          if (s_r.txTick[3:0] == TICKS_LAST) begin
            s_nxt.txTick = 6'h00;
            s_nxt.txBit  = 3'h0;
            s_nxt.txSt   = TX_DATA;
          end
        end
        TX_DATA: begin
          if (s_r.txTick[3:0] == TICKS_LAST) begin
            s_nxt.txTick = 6'h00;
            s_nxt.txSh   = s_r.txSh >> 1;
            s_nxt.txBit  = s_r.txBit + 3'h1;
            if (s_r.txBit == lastBit) begin
              s_nxt.txSt = s_r.lineCtrl[LC_PAR_EN] ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (s_r.txTick[3:0] == TICKS_LAST) begin
            s_nxt.txTick = 6'h00;
            s_nxt.txSt   = TX_STOP;
          end
        end
        TX_STOP: begin
          if (s_r.txTick == stopLast) begin
            s_nxt.txSt = TX_IDLE;
          end
        end
        default: s_nxt.txSt = TX_IDLE;
      endcase
    end

    // infrared pulse stretcher
    if (irOn & rxPin) begin
      s_nxt.irHold = IR_STRETCH;
    end else if (tick & (s_r.irHold != 5'h00)) begin
      s_nxt.irHold = s_r.irHold - 5'h01;
    end

    // receiver
    if (s_r.rxSt == RX_IDLE) begin
      if (s_r.brkHold) begin
        s_nxt.brkHold = ~rxLine;
      end else if (~rxLine) begin
        s_nxt.rxTick = 4'h0;
        s_nxt.rxSh   = 8'h00;
        s_nxt.rxSt   = RX_START;
      end
    end else if (tick) begin
      s_nxt.rxTick = s_r.rxTick + 4'h1;
      case (s_r.rxSt)
        RX_START: begin
          if (s_r.rxTick == TICKS_MID) begin
            s_nxt.rxTick = 4'h0;
            s_nxt.rxBit  = 3'h0;
            s_nxt.rxZero = 1'b1;
            s_nxt.rxSt   = rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (s_r.rxTick == TICKS_LAST) begin
            s_nxt.rxSh[s_r.rxBit] = rxLine;
            s_nxt.rxZero = s_r.rxZero & ~rxLine;
            s_nxt.rxBit  = s_r.rxBit + 3'h1;
            if (s_r.rxBit == lastBit) begin
              s_nxt.rxSt = s_r.lineCtrl[LC_PAR_EN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (s_r.rxTick == TICKS_LAST) begin
            s_nxt.rxPar  = rxLine;
            s_nxt.rxZero = s_r.rxZero & ~rxLine;
            s_nxt.rxSt   = RX_STOP;
          end
        end
        RX_STOP: begin
          if (s_r.rxTick == TICKS_LAST) begin
            s_nxt.rxSt   = RX_IDLE;
            brk          = s_r.rxZero & ~rxLine;
            pushReq      = 1'b1;
            if (brk) begin
              pushVal       = '{brk: 1'b1, frm: 1'b1, par: 1'b0, data: 8'h00};
              s_nxt.brkHold = 1'b1;
            end else begin
              pushVal.data = s_r.rxSh;
              pushVal.frm  = ~rxLine;
              pushVal.par  = s_r.lineCtrl[LC_PAR_EN] &
                             (s_r.rxPar != parityBit(s_r.rxSh, s_r.lineCtrl));
              isFlow = s_r.cfgBits[CF_SW_FLOW] &
                       ((s_r.rxSh == CHAR_XON) | (s_r.rxSh == CHAR_XOFF));
              if (s_r.modemCtrl[MC_XON_ANY]) begin
                s_nxt.halted = 1'b0;
              end
              if (s_r.cfgBits[CF_SW_FLOW] & (s_r.rxSh == CHAR_XON)) begin
                s_nxt.halted = 1'b0;
              end
              if (s_r.cfgBits[CF_SW_FLOW] & (s_r.rxSh == CHAR_XOFF)) begin
                s_nxt.halted = 1'b1;
              end
              pushReq = ~isFlow;
            end
          end
        end
        default: s_nxt.rxSt = RX_IDLE;
      endcase
    end

    // receive fifo; a full fifo keeps its contents and flags overrun
    pushOk = pushReq & (~fifoFull | pop);
    if (pushReq & ~pushOk) begin
      s_nxt.overrun = 1'b1;
      s_nxt.lsInt   = 1'b1;
    end
    if (pushOk) begin
      s_nxt.mem[wrPtr] = pushVal;
    end
    if (pop) begin
      s_nxt.rdPtr = nxtPtr;
    end
    s_nxt.count = s_r.count + (AW+1)'(pushOk) - (AW+1)'(pop);
    // interrupt as an errored character reaches the head
    if (pop) begin
      nextHead = (s_r.count > (AW+1)'(1)) ? s_r.mem[nxtPtr] : pushVal;
      headEvt  = (s_r.count > (AW+1)'(1)) | pushOk;
    end else begin
      nextHead = pushVal;
      headEvt  = pushOk & ~dataReady;
    end
    if (headEvt & (nextHead.brk | nextHead.frm | nextHead.par)) begin
      s_nxt.lsInt = 1'b1;
    end
    if (flush) begin
      s_nxt.count = '0;
      s_nxt.rdPtr = '0;
    end

    if (reset) begin
      s_nxt           = '0;
      s_nxt.lineCtrl  = RST_LINE_CTRL;
      s_nxt.modemCtrl = RST_MODEM_CTRL;
      s_nxt.alertEn   = RST_ENABLE;
      s_nxt.divLow    = RST_DIV_LOW;
      s_nxt.divHigh   = RST_DIV_HIGH;
      s_nxt.txSt      = TX_IDLE;
      s_nxt.rxSt      = RX_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || ce) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign readdata    = {24'h000000, s_r.rdData};
  assign waitrequest = req & ~s_r.ack;

  assign modemOut.termReadyN = ~s_r.modemCtrl[MC_TERM_RDY];
  assign modemOut.reqSendN   = ~s_r.modemCtrl[MC_REQ_SEND];
  assign modemOut.auxTwoN    = ~s_r.modemCtrl[MC_AUX_TWO];

  assign irqOut          = intActive;
  // the push-pull interrupt floats unless bit 3 enables it and the alternate bus bit is clear
  assign irqDriveN       = ~(s_r.modemCtrl[MC_AUX_TWO] & ~s_r.cfgBits[CF_ALT_BUS]);
  assign irqSharedOut    = 1'b0;
  assign irqSharedDriveN = ~(s_r.cfgBits[CF_ALT_BUS] & intActive);

endmodule : uart_line_format_modem_status

// file: test/uart_lfms_sva.sv
`timescale 1ns/10ps
module uart_lfms_sva
  import uart_lfms_pkg::*;
(
  // watched ports
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        txPin,
  input wire modem_out_t  modemOut,
  input wire logic        irqDriveN,
  input wire logic        irqSharedOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence mc_done;
    write && !waitrequest && ce && byteenable[0] && address == OFS_MODEM_CTRL;
  endsequence
  sequence brk_on;
    write && !waitrequest && ce && byteenable[0] && address == OFS_LINE_CTRL
      && writedata[LC_BREAK];
  endsequence
  chk_one_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("request without single wait cycle");
  chk_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_dtr_drive: assert property (
    mc_done |=> modemOut.termReadyN == !$past(writedata[MC_TERM_RDY]))
    else $error("terminal ready output wrong");
  chk_rts_drive: assert property (
    mc_done |=> modemOut.reqSendN == !$past(writedata[MC_REQ_SEND]))
    else $error("request to send output wrong");
  chk_aux_drive: assert property (
    mc_done |=> modemOut.auxTwoN == !$past(writedata[MC_AUX_TWO]))
    else $error("aux output wrong");
  chk_irq_enable: assert property (!irqDriveN |-> !modemOut.auxTwoN)
    else $error("interrupt driven while disabled");
  chk_break_low: assert property (brk_on |=> !txPin [*3])
    else $error("break not held low");
  chk_shared_idle: assert property (irqSharedOut == 1'b0)
    else $error("shared interrupt level not low");
endmodule : uart_lfms_sva

bind uart_line_format_modem_status uart_lfms_sva u_sva (.clock(clock), .reset(reset),
  .ce(ce), .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .txPin(txPin),
  .modemOut(modemOut), .irqDriveN(irqDriveN), .irqSharedOut(irqSharedOut));

// file: test/uart_far_end.sv
`timescale 1ns/10ps
module uart_far_end (
  // serial line
  input  wire logic clock,
  output logic      rxLine
);
  initial rxLine = 1'b1;
  // bits go lsb first, 16 clocks each (divisor one); line back to mark after
  // last sets the clocks of the final bit; a short low stop avoids a false restart
  task automatic frame(input logic [11:0] bits, input int n, input int last = 16);
    for (int i = 0; i < n; i++) begin
      rxLine <= bits[i];
      repeat ((i == n - 1) ? last : 16) @(posedge clock);
    end
    rxLine <= 1'b1;
    @(posedge clock);
  endtask : frame
  task automatic low(input int cycles);
    rxLine <= 1'b0;
    repeat (cycles) @(posedge clock);
    rxLine <= 1'b1;
  endtask : low
endmodule : uart_far_end

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import uart_lfms_pkg::*;
;
  logic        clock, reset, read, write, waitrequest, txPin, rxPin;
  logic        irqOut, irqDriveN, irqSharedOut, irqSharedDriveN;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  modem_out_t  modemOut;
  logic [7:0]  q;
  int          errCount = 0, samplesChecked = 0, cyc = 0;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  uart_line_format_modem_status u_uart_line_format_modem_status (.clock(clock),
    .reset(reset), .ce(1'h1), .address(address), .read(read), .write(write),
    .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rxPin(rxPin), .txPin(txPin), .ringIndicatorInN(1'h1),
    .modemOut(modemOut), .irqOut(irqOut), .irqDriveN(irqDriveN),
    .irqSharedOut(irqSharedOut), .irqSharedDriveN(irqSharedDriveN));
  uart_far_end u_uart_far_end (.clock(clock), .rxLine(rxPin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount++;
      results();
    end
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // request held up to the edge that sees waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    address   <= a;
    write     <= wr;
    read      <= !wr;
    writedata <= {24'h000000, d};
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    q = readdata[7:0];
    write <= 1'h0;
    read  <= 1'h0;
    @(posedge clock);
  endtask : bus
  task automatic rd(input logic [4:0] a, input logic [7:0] mask, input logic [7:0] exp);
    bus(1'h0, a, 8'h00);
    cmp(q & mask, exp);
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_modem();
    logic [7:0] v [5] = '{8'h01, 8'h02, 8'h08, 8'h0B, 8'h00};
    rd(OFS_LINE_CTRL, 8'hFF, RST_LINE_CTRL);
    rd(OFS_MODEM_CTRL, 8'hFF, RST_MODEM_CTRL);
    foreach (v[i]) begin
      bus(1'h1, OFS_MODEM_CTRL, v[i]);
      cmp({5'h00, modemOut}, {5'h00, ~v[i][0], ~v[i][1], ~v[i][3]});
      cmp({7'h00, irqDriveN}, {7'h00, ~v[i][3]});
      rd(OFS_MODEM_CTRL, 8'hFF, v[i]);
    end
  endtask : t_modem
  task automatic t_divisor();
    bus(1'h1, OFS_LINE_CTRL, 8'h80);
    bus(1'h1, OFS_DATA, 8'h34);
    bus(1'h1, OFS_ENABLE, 8'h12);
    rd(OFS_DATA, 8'hFF, 8'h34);
    rd(OFS_ENABLE, 8'hFF, 8'h12);
    bus(1'h1, OFS_DATA, 8'h01);
    bus(1'h1, OFS_ENABLE, 8'h00);
    bus(1'h1, OFS_LINE_CTRL, 8'h03);
    bus(1'h1, OFS_ENABLE, 8'h05);
    rd(OFS_ENABLE, 8'hFF, 8'h05);
    bus(1'h1, OFS_ENABLE, 8'h00);
  endtask : t_divisor
  task automatic t_break_tx();
    logic [9:0] bits = {1'h1, 8'h55, 1'h0};
    bus(1'h1, OFS_LINE_CTRL, 8'h43);
    repeat (4) @(posedge clock);
    cmp({7'h00, txPin}, 8'h00);
    bus(1'h1, OFS_LINE_CTRL, 8'h03);
    cmp({7'h00, txPin}, 8'h01);
    bus(1'h1, OFS_DATA, 8'h55);
    repeat (7) @(negedge clock);
    for (int i = 0; i < 10; i++) begin
      cmp({7'h00, txPin}, {7'h00, bits[i]});
      repeat (16) @(negedge clock);
    end
    @(posedge clock);
  endtask : t_break_tx
  task automatic t_rx_parity();
    bus(1'h1, OFS_LINE_CTRL, 8'h1B);
    u_uart_far_end.frame({1'h1, 1'h0, 8'hA5, 1'h0}, 11);
    rd(OFS_LINE_STAT, 8'h1F, 8'h01);
    rd(OFS_DATA, 8'hFF, 8'hA5);
    rd(OFS_LINE_STAT, 8'h1F, 8'h00);
    u_uart_far_end.frame({1'h1, 1'h1, 8'hA5, 1'h0}, 11);
    u_uart_far_end.frame({1'h1, 1'h0, 8'h3C, 1'h0}, 11);
    rd(OFS_LINE_STAT, 8'h1F, 8'h07);
    rd(OFS_DATA, 8'hFF, 8'hA5);
    rd(OFS_LINE_STAT, 8'h1F, 8'h00);
    bus(1'h1, OFS_LINE_CTRL, 8'h3B);
    u_uart_far_end.frame({1'h1, 1'h0, 8'hA4, 1'h0}, 11);
    rd(OFS_LINE_STAT, 8'h1F, 8'h01);
    rd(OFS_DATA, 8'hFF, 8'hA4);
  endtask : t_rx_parity
  task automatic t_rx_errors();
    bus(1'h1, OFS_LINE_CTRL, 8'h03);
    u_uart_far_end.frame({1'h0, 8'h5A, 1'h0}, 10, 12);
    bus(1'h1, OFS_ENABLE, 8'h04);
    bus(1'h1, OFS_CONFIG, 8'h01);
    cmp({5'h00, irqOut, irqDriveN, irqSharedDriveN}, 8'h06);
    rd(OFS_LINE_STAT, 8'h1F, 8'h09);
    cmp({5'h00, irqOut, irqDriveN, irqSharedDriveN}, 8'h03);
    bus(1'h1, OFS_CONFIG, 8'h00);
    bus(1'h1, OFS_ENABLE, 8'h00);
    rd(OFS_DATA, 8'hFF, 8'h5A);
    bus(1'h1, OFS_LINE_CTRL, 8'h00);
    u_uart_far_end.frame({1'h1, 5'h15, 1'h0}, 7);
    rd(OFS_DATA, 8'hFF, 8'h15);
    u_uart_far_end.low(200);
    rd(OFS_LINE_STAT, 8'h10, 8'h10);
    rd(OFS_DATA, 8'hFF, 8'h00);
    rd(OFS_LINE_STAT, 8'h1F, 8'h00);
  endtask : t_rx_errors
  task automatic t_loop();
    bus(1'h1, OFS_LINE_CTRL, 8'h03);
    bus(1'h1, OFS_MODEM_CTRL, 8'h10);
    bus(1'h1, OFS_DATA, 8'hC3);
    repeat (20) @(posedge clock);
    cmp({7'h00, txPin}, 8'h01);
    repeat (200) @(posedge clock);
    rd(OFS_DATA, 8'hFF, 8'hC3);
    bus(1'h1, OFS_MODEM_CTRL, 8'h14);
    rd(OFS_CONFIG, 8'h10, 8'h10);
    bus(1'h1, OFS_MODEM_CTRL, 8'h00);
    rd(OFS_CONFIG, 8'h10, 8'h00);
  endtask : t_loop
  initial begin
    reset = 1'h1;
    read = 1'h0;
    write = 1'h0;
    address = 5'h00;
    writedata = 32'h00000000;
    repeat (16) @(posedge clock);
    reset <= 1'h0;
    @(posedge clock);
    t_modem();
    t_divisor();
    t_break_tx();
    t_rx_parity();
    t_rx_errors();
    t_loop();
    results();
  end
endmodule : tb_top
